// file: inc/pmc_pkg.sv
// Package: constants and types for the performance monitor counter block
package pmc_pkg;
    localparam int CLK_HZ = 40000000;
    localparam real SNAP_PERIOD_S = 1.0;
    localparam int SNAP_CYCLES = int'(SNAP_PERIOD_S * CLK_HZ);
    localparam int NCNT = 7;
    localparam int NBYTE = 16;
    // Software port offsets
    localparam logic [3:0] OFS_CTRL = 4'h0;
    localparam logic [3:0] OFS_IRQ_FLAG = 4'h1;
    localparam logic [3:0] OFS_IRQ_EN = 4'h2;
    localparam logic [3:0] OFS_ACCESS = 4'h3;
    localparam logic [3:0] OFS_DATA = 4'h4;
    localparam logic [3:0] OFS_FORMAT = 4'h5;
    // Control and access bit positions
    localparam int BIT_AUTO = 0;
    localparam int BIT_MANUAL = 1;
    localparam int BIT_LINK = 4;
    // Counter indices within flag and enable registers
    localparam int C_CRC = 0;
    localparam int C_FER = 1;
    localparam int C_ALIGNMENT_SHIFT_COUNT = 2;
    localparam int C_OOF = 3;
    localparam int C_PATTERN_CHECKER_ERROR_COUNT = 4;
    localparam int C_LCV = 5;
    localparam int C_DDS = 6;
    // Counter widths
    localparam int W_LCV = 16;
    localparam int W_FER = 12;
    localparam int W_ALIGNMENT_SHIFT_COUNT = 3;
    localparam int W_OOF = 5;
    localparam int W_PATTERN_CHECKER_ERROR_COUNT = 16;
    localparam int W_CRC = 10;
    localparam int W_DDS = 10;
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [6:0] IRQ_EN_RST = 7'h00;
    typedef enum logic [1:0] {PMC_SF, PMC_ESF, PMC_DM, PMC_SLC} pmc_format_t;
endpackage : pmc_pkg

// file: inc/pmc_snap_if.sv
// Interface: snapshot write and indirect read between top and memory
`timescale 1ns/1ps
interface pmc_snap_if;
    logic wr;
    logic [7:0] wdata [2*16];
    logic [4:0] raddr;
    logic [7:0] rdata;
    modport top (output wr, output wdata, output raddr, input rdata);
    modport mem (input wr, input wdata, input raddr, output rdata);
endinterface : pmc_snap_if

// file: src/pmc_snap_mem.sv
// Snapshot memory: indirect byte registers for two links, registered read
`timescale 1ns/1ps
module pmc_snap_mem
    import pmc_pkg::*;
(
    input wire logic sys_clk_i, // System clock
    input wire logic rst_i, // Synchronous reset
    pmc_snap_if.mem snap // Snapshot port
);
    logic [7:0] mem [2*NBYTE];
    logic [7:0] rdata;

    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
        begin
            for (int i = 0; i < 2*NBYTE; i++)
                mem[i] <= 8'h00;
            rdata <= 8'h00;
        end
        else
        begin
            if (snap.wr)
                for (int i = 0; i < 2*NBYTE; i++)
                    mem[i] <= snap.wdata[i];
            rdata <= mem[snap.raddr];
        end
    end

    assign snap.rdata = rdata;
endmodule : pmc_snap_mem

// file: src/pmc_monitor.sv
// Performance monitor counters with snapshot, overflow interrupts and access port
//
// The address-and-strobe port and the register addresses were decided locally.
`timescale 1ns/1ps
module pmc_monitor
    import pmc_pkg::*;
#(
    parameter int SNAP_CYC = SNAP_CYCLES // Cycles per auto snapshot
)
(
    input wire logic sys_clk_i, // 40 MHz clock
    input wire logic rst_i, // Synchronous reset, high
    input wire logic [1:0] lcv_ev_i, // Line code violation pulse per link
    input wire logic [1:0] fer_ev_i, // Framing error pulse per link
    input wire logic [1:0] alignment_shift_count_ev_i, // Alignment shift pulse per link
    input wire logic [1:0] oof_ev_i, // Out of sync pulse per link
    input wire logic [1:0] pattern_checker_error_count_ev_i, // Pattern checker error pulse per link
    input wire logic [1:0] crc_ev_i, // CRC-6 error pulse per link
    input wire logic [1:0] dds_ev_i, // DDS pattern error pulse per link
    input wire logic [3:0] addr_i, // Register address
    input wire logic [7:0] wdata_i, // Write data
    input wire logic wr_i, // Write strobe
    input wire logic rd_i, // Read strobe
    output logic [7:0] rdata_o, // Read data, cycle after strobe
    output logic irq_o // Level interrupt
);
    ////////////////////////////////////////////////////////////////////////
    // Saturating increment used by every counter
    function automatic logic [15:0] sat_inc(input logic [15:0] v, input logic ev,
                                            input int w);
        logic [15:0] maxv;
        maxv = 16'((32'h1 << w) - 1);
        return (ev && v != maxv) ? 16'(v + 16'h1) : v;
    endfunction : sat_inc

    logic [7:0] ctrl;
    logic [7:0] access;
    logic [1:0] fmt;
    logic [6:0] irq_flag [2];
    logic [6:0] irq_en [2];
    logic manual_q;
    logic [31:0] sec_cnt;
    logic [15:0] cnt [2][NCNT];
    logic [7:0] rdata;

    wire auto_snapshot_enable = ctrl[BIT_AUTO];
    wire manual_snapshot_trigger = ctrl[BIT_MANUAL];
    wire link_select = access[BIT_LINK];
    wire sec_tick = (sec_cnt == 32'(SNAP_CYC - 1));
    wire manual_rise = manual_snapshot_trigger && !manual_q;
    wire snap = (auto_snapshot_enable && sec_tick) || manual_rise;
    wire pmc_format_t cur_fmt = pmc_format_t'(fmt);
    wire wr_flag = wr_i && addr_i == OFS_IRQ_FLAG;

    pmc_snap_if snap_bus ();

    pmc_snap_mem u_mem (
        .sys_clk_i(sys_clk_i),
        .rst_i(rst_i),
        .snap(snap_bus.mem)
    );

    ////////////////////////////////////////////////////////////////////////
    // Software registers
    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
        begin
            ctrl <= CTRL_RST;
            access <= 8'h00;
            fmt <= 2'h0;
            irq_en[0] <= IRQ_EN_RST;
            irq_en[1] <= IRQ_EN_RST;
        end
        else if (wr_i)
        begin
            if (addr_i == OFS_CTRL)
                ctrl <= wdata_i;
            if (addr_i == OFS_ACCESS)
                access <= wdata_i;
            if (addr_i == OFS_FORMAT)
                fmt <= wdata_i[1:0];
            if (addr_i == OFS_IRQ_EN)
                irq_en[wdata_i[7]] <= wdata_i[6:0];
        end
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
            manual_q <= 1'b0;
        else
            manual_q <= manual_snapshot_trigger;
    end

    // Free running second counter; auto enable only gates its use
    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i || sec_tick)
            sec_cnt <= 32'h0;
        else
            sec_cnt <= sec_cnt + 32'h1;
    end

    ////////////////////////////////////////////////////////////////////////
    // Counters, per link
    logic ev [2][NCNT];
    logic [NCNT-1:0] ovf [2];
    logic [15:0] next_cnt [2][NCNT];
    int wid [NCNT];

    always_comb
    begin
        wid[C_CRC] = W_CRC;
        wid[C_FER] = W_FER;
        wid[C_ALIGNMENT_SHIFT_COUNT] = W_ALIGNMENT_SHIFT_COUNT;
        wid[C_OOF] = W_OOF;
        wid[C_PATTERN_CHECKER_ERROR_COUNT] = W_PATTERN_CHECKER_ERROR_COUNT;
        wid[C_LCV] = W_LCV;
        wid[C_DDS] = W_DDS;
        for (int l = 0; l < 2; l++)
        begin
            ev[l][C_LCV] = lcv_ev_i[l];
            ev[l][C_OOF] = oof_ev_i[l];
            ev[l][C_PATTERN_CHECKER_ERROR_COUNT] = pattern_checker_error_count_ev_i[l];
            ev[l][C_ALIGNMENT_SHIFT_COUNT] = alignment_shift_count_ev_i[l];
            ev[l][C_FER] = fer_ev_i[l];
            ev[l][C_CRC] = crc_ev_i[l] && cur_fmt == PMC_ESF;
            ev[l][C_DDS] = dds_ev_i[l] && cur_fmt == PMC_DM;
            for (int c = 0; c < NCNT; c++)
            begin
                // New interval starts from the coinciding event
                if (snap)
                    next_cnt[l][c] = {15'h0, ev[l][c]};
                else
                    next_cnt[l][c] = sat_inc(cnt[l][c], ev[l][c], wid[c]);
                ovf[l][c] = ev[l][c] && !snap &&
                            cnt[l][c] == 16'((32'h1 << wid[c]) - 1);
            end
        end
    end

    always_ff @(posedge sys_clk_i)
    begin
        for (int l = 0; l < 2; l++)
            for (int c = 0; c < NCNT; c++)
                cnt[l][c] <= rst_i ? 16'h0 : next_cnt[l][c];
    end

    // Set wins over the write-one clear
    always_ff @(posedge sys_clk_i)
    begin
        for (int l = 0; l < 2; l++)
            if (rst_i)
                irq_flag[l] <= 7'h00;
            else
                irq_flag[l] <= (irq_flag[l] & ~((wr_flag && wdata_i[7] == 1'(l)) ?
                                wdata_i[6:0] : 7'h00)) | ovf[l];
    end

    assign irq_o = |(irq_flag[0] & irq_en[0]) || |(irq_flag[1] & irq_en[1]);

    ////////////////////////////////////////////////////////////////////////
    // Snapshot byte map: byte index = counter index * 2 + half
    always_comb
    begin
        for (int l = 0; l < 2; l++)
            for (int b = 0; b < NBYTE; b++)
                snap_bus.wdata[l*NBYTE + b] = 8'h00;
        for (int l = 0; l < 2; l++)
            for (int c = 0; c < NCNT; c++)
            begin
                snap_bus.wdata[l*NBYTE + 2*c] = cnt[l][c][7:0];
                snap_bus.wdata[l*NBYTE + 2*c + 1] = cnt[l][c][15:8];
            end
    end
    assign snap_bus.wr = snap;
    assign snap_bus.raddr = {link_select, access[3:0]};

    ////////////////////////////////////////////////////////////////////////
    // Read port: decode at the strobe, hold the byte for one cycle
    always_comb
    begin
        unique case (addr_i)
            OFS_CTRL: rdata = ctrl;
            OFS_IRQ_FLAG: rdata = {1'b0, irq_flag[link_select]};
            OFS_IRQ_EN: rdata = {1'b0, irq_en[link_select]};
            OFS_ACCESS: rdata = access;
            OFS_DATA: rdata = snap_bus.rdata;
            OFS_FORMAT: rdata = {6'h0, fmt};
            default: rdata = 8'h00;
        endcase
    end

    // Registered byte keeps decode glitches off the bus
    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i || !rd_i)
            rdata_o <= 8'h00;
        else
            rdata_o <= rdata;
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    // Snapshot copy, clear and auto period
    a_snap_clears: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        snap |=> cnt[0][C_LCV] == 16'($past(lcv_ev_i[0])))
        else $error("counter not cleared after snapshot");
    a_manual_snap: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        $rose(manual_snapshot_trigger) |=>
        u_mem.mem[2*C_OOF] == $past(cnt[0][C_OOF][7:0]))
        else $error("manual rise did not snapshot");
    a_auto_snap: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (auto_snapshot_enable && sec_tick) |=>
        u_mem.mem[2*C_PATTERN_CHECKER_ERROR_COUNT] == $past(cnt[0][C_PATTERN_CHECKER_ERROR_COUNT][7:0]))
        else $error("auto snapshot missing");
    a_tick_range: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        sec_cnt <= 32'(SNAP_CYC - 1))
        else $error("second counter past its period");
    a_link_map: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        snap |=> u_mem.mem[NBYTE + 2*C_LCV] == $past(cnt[1][C_LCV][7:0]))
        else $error("link one snapshot misplaced");

    // Counting, gating and saturation
    a_event_kept: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (snap && lcv_ev_i[1]) |=> cnt[1][C_LCV] == 16'h1)
        else $error("event lost at snapshot");
    a_alignment_shift_count_sat: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        cnt[0][C_ALIGNMENT_SHIFT_COUNT] <= 16'h7)
        else $error("alignment counter exceeds width");
    a_oof_sat: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        cnt[0][C_OOF] <= 16'h1F)
        else $error("out of sync counter exceeds width");
    a_fer_sat: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        cnt[1][C_FER] <= 16'hFFF)
        else $error("framing counter exceeds width");
    a_crc_sat: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        cnt[0][C_CRC] <= 16'h3FF)
        else $error("crc counter exceeds width");
    a_crc_fmt: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (cur_fmt != PMC_ESF && !snap) |=> $stable(cnt[0][C_CRC]))
        else $error("crc counted outside esf");
    a_dds_fmt: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (cur_fmt != PMC_DM && !snap) |=> $stable(cnt[0][C_DDS]))
        else $error("dds counted outside t1 dm");
    a_pattern_checker_error_count_idle: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (!snap && !pattern_checker_error_count_ev_i[0]) |=> $stable(cnt[0][C_PATTERN_CHECKER_ERROR_COUNT]))
        else $error("pattern counter moved without event");
    a_lcv_idle: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (!snap && !lcv_ev_i[1]) |=> $stable(cnt[1][C_LCV]))
        else $error("line code counter moved without event");
    a_alignment_shift_count_idle: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (!snap && !alignment_shift_count_ev_i[1]) |=> $stable(cnt[1][C_ALIGNMENT_SHIFT_COUNT]))
        else $error("alignment counter moved without event");
    a_ovf_hold: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        ovf[0][C_OOF] |=> cnt[0][C_OOF] == 16'h1F)
        else $error("counter wrapped after overflow");

    // Flags and interrupt
    a_flag_sticky: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (irq_flag[0][C_OOF] && !wr_flag) |=> irq_flag[0][C_OOF])
        else $error("flag cleared without write");
    a_flag_clear: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (wr_flag && !wdata_i[7] && wdata_i[C_OOF] && !ovf[0][C_OOF]) |=> !irq_flag[0][C_OOF])
        else $error("flag kept after write one");
    a_irq_gate: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (irq_en[0] == 7'h00 && irq_en[1] == 7'h00) |-> !irq_o)
        else $error("interrupt without enable");
    a_ovf_flag: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        ovf[1][C_ALIGNMENT_SHIFT_COUNT] |=> irq_flag[1][C_ALIGNMENT_SHIFT_COUNT])
        else $error("overflow flag not set");

    // Read port
    a_read_data: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        !$past(rd_i) |-> rdata_o == 8'h00)
        else $error("read data outside read slot");

    c_manual: cover property (@(posedge sys_clk_i) disable iff (rst_i) manual_rise);
    c_auto: cover property (@(posedge sys_clk_i) disable iff (rst_i)
        auto_snapshot_enable && sec_tick);
    c_irq: cover property (@(posedge sys_clk_i) disable iff (rst_i) irq_o);
    c_overflow: cover property (@(posedge sys_clk_i) disable iff (rst_i) ovf[0][C_OOF]);
    c_coincide: cover property (@(posedge sys_clk_i) disable iff (rst_i) snap && lcv_ev_i[1]);
endmodule : pmc_monitor

// file: verif/pmc_ev_src.sv
// Event source model: framer, line decoder and pattern checker pulses
`timescale 1ns/1ps
module pmc_ev_src
    import pmc_pkg::*;
(
    input wire logic sys_clk_i, // Clock
    input wire logic fire_i, // One pulse per cycle while high
    input wire logic [2:0] kind_i, // Counter index of the event
    input wire logic link_i, // Link that sees the event
    output logic [1:0] ev_o [NCNT] // Pulses, one vector per counter
);
    // Idle lines are driven low: pulses are active high, one cycle each
    always_ff @(posedge sys_clk_i)
    begin
        for (int k = 0; k < NCNT; k++)
            ev_o[k] <= (fire_i && kind_i == 3'(k)) ? (2'h1 << link_i) : 2'h0;
    end
endmodule : pmc_ev_src

// file: verif/pmc_monitor_bench.sv
// Testbench for the performance monitor counter block
`timescale 1ns/1ps
module pmc_monitor_bench;
    import pmc_pkg::*;
    // Short auto period keeps the run small
    localparam int SC = 50;
    typedef struct {pmc_format_t f; int c; logic l; int n; logic [7:0] e;} pmc_row_t;
    logic sys_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic fire = 1'b0;
    logic link = 1'b0;
    logic [2:0] kind = 3'h0;
    logic [3:0] addr_i = 4'h0;
    logic [7:0] wdata_i = 8'h00;
    logic [7:0] rdata_o, d, s;
    logic irq_o;
    logic [1:0] ev [NCNT];
    int error_cnt = 0;
    int comparisons = 0;
    int cyc = 0;
    // Format-gated counters must stay at zero outside their format
    pmc_row_t rows [9] = '{'{PMC_SF, C_LCV, 1'b0, 5, 8'h05}, '{PMC_ESF, C_CRC, 1'b1, 3, 8'h03},
        '{PMC_SF, C_CRC, 1'b0, 3, 8'h00}, '{PMC_DM, C_DDS, 1'b1, 4, 8'h04},
        '{PMC_ESF, C_DDS, 1'b0, 2, 8'h00}, '{PMC_SLC, C_FER, 1'b1, 6, 8'h06},
        '{PMC_SF, C_ALIGNMENT_SHIFT_COUNT, 1'b0, 2, 8'h02}, '{PMC_DM, C_OOF, 1'b1, 7, 8'h07},
        '{PMC_ESF, C_PATTERN_CHECKER_ERROR_COUNT, 1'b0, 9, 8'h09}};

    pmc_monitor #(.SNAP_CYC(SC)) dut (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
        .lcv_ev_i(ev[C_LCV]), .fer_ev_i(ev[C_FER]), .alignment_shift_count_ev_i(ev[C_ALIGNMENT_SHIFT_COUNT]),
        .oof_ev_i(ev[C_OOF]), .pattern_checker_error_count_ev_i(ev[C_PATTERN_CHECKER_ERROR_COUNT]), .crc_ev_i(ev[C_CRC]),
        .dds_ev_i(ev[C_DDS]), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
        .rd_i(rd_i), .rdata_o(rdata_o), .irq_o(irq_o));
    pmc_ev_src src (.sys_clk_i(sys_clk_i), .fire_i(fire), .kind_i(kind), .link_i(link),
        .ev_o(ev));

    initial
    begin
        forever #12.5 sys_clk_i = ~sys_clk_i;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        comparisons++;
        if (g !== e)
        begin
            error_cnt++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk

    task automatic wr_reg(input logic [3:0] a, input logic [7:0] v);
        @(posedge sys_clk_i);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= v;
        @(posedge sys_clk_i);
        wr_i <= 1'b0;
    endtask : wr_reg

    task automatic rd_reg(input logic [3:0] a, output logic [7:0] v);
        @(posedge sys_clk_i);
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge sys_clk_i);
        rd_i <= 1'b0;
        #1 v = rdata_o;
    endtask : rd_reg

    task automatic rd_cnt(input logic l, input logic [3:0] i, output logic [7:0] v);
        wr_reg(OFS_ACCESS, {3'h0, l, i});
        rd_reg(OFS_DATA, v);
    endtask : rd_cnt

    task automatic snap();
        wr_reg(OFS_CTRL, 8'h00);
        wr_reg(OFS_CTRL, 8'h02);
        repeat (2) @(posedge sys_clk_i);
    endtask : snap

    task automatic fire_n(input int k, input logic l, input int n);
        @(posedge sys_clk_i);
        fire <= 1'b1;
        kind <= 3'(k);
        link <= l;
        repeat (n) @(posedge sys_clk_i);
        fire <= 1'b0;
        repeat (2) @(posedge sys_clk_i);
    endtask : fire_n

    task automatic conclude();
        $display("comparisons %0d, mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : conclude

    ////////////////////////////////////////////////////////////////////////////////
    // Ceiling well above the few hundred cycles the tests need
    always @(posedge sys_clk_i)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            error_cnt++;
            conclude();
        end
    end

    initial
    begin
        repeat (4) @(posedge sys_clk_i);
        rst_i <= 1'b0;
        rd_reg(OFS_CTRL, d);
        chk(d, CTRL_RST);
        rd_reg(OFS_IRQ_EN, d);
        chk(d, {1'b0, IRQ_EN_RST});
        chk({7'h00, irq_o}, 8'h00);
        $display("test reset done");
        foreach (rows[i])
        begin
            wr_reg(OFS_FORMAT, {6'h00, rows[i].f});
            fire_n(rows[i].c, rows[i].l, rows[i].n);
            snap();
            rd_cnt(rows[i].l, 4'(2 * rows[i].c), d);
            chk(d, rows[i].e);
        end
        $display("test table done");
        snap();
        rd_cnt(1'b0, 4'hA, d);
        chk(d, 8'h00);
        // Events run straight through a snapshot; the two intervals must sum up
        fork
            fire_n(C_LCV, 1'b1, 12);
            begin
                repeat (4) @(posedge sys_clk_i);
                snap();
            end
        join
        rd_cnt(1'b1, 4'hA, s);
        snap();
        rd_cnt(1'b1, 4'hA, d);
        chk(s + d, 8'h0C);
        $display("test coincident done");
        fire_n(C_OOF, 1'b0, 40);
        fire_n(C_ALIGNMENT_SHIFT_COUNT, 1'b1, 8);
        snap();
        rd_cnt(1'b0, 4'h6, d);
        chk(d, 8'h1F);
        rd_reg(OFS_IRQ_FLAG, d);
        chk(d, 8'h08);
        chk({7'h00, irq_o}, 8'h00);
        wr_reg(OFS_IRQ_EN, 8'h08);
        #1 chk({7'h00, irq_o}, 8'h01);
        wr_reg(OFS_IRQ_FLAG, 8'h08);
        #1 chk({7'h00, irq_o}, 8'h00);
        rd_reg(OFS_IRQ_FLAG, d);
        chk(d, 8'h00);
        rd_cnt(1'b1, 4'h4, d);
        chk(d, 8'h07);
        rd_reg(OFS_IRQ_FLAG, d);
        chk(d, 8'h04);
        wr_reg(OFS_IRQ_EN, 8'h84);
        #1 chk({7'h00, irq_o}, 8'h01);
        wr_reg(OFS_IRQ_FLAG, 8'h84);
        #1 chk({7'h00, irq_o}, 8'h00);
        $display("test overflow done");
        // Tick phase is unknown, so poll until the captured value shows
        wr_reg(OFS_CTRL, 8'h01);
        fire_n(C_ALIGNMENT_SHIFT_COUNT, 1'b1, 1);
        wr_reg(OFS_ACCESS, 8'h14);
        d = 8'h00;
        for (int t = 0; t < 40 && d !== 8'h01; t++)
            rd_reg(OFS_DATA, d);
        chk(d, 8'h01);
        wr_reg(OFS_CTRL, 8'h00);
        $display("test auto done");
        // Reset in mid-run must wipe snapshots and enables and leave irq_o low
        fire_n(C_PATTERN_CHECKER_ERROR_COUNT, 1'b0, 3);
        snap();
        rd_cnt(1'b0, 4'h8, d);
        chk(d, 8'h03);
        @(posedge sys_clk_i);
        rst_i <= 1'b1;
        repeat (4) @(posedge sys_clk_i);
        rst_i <= 1'b0;
        rd_cnt(1'b0, 4'h8, d);
        chk(d, 8'h00);
        rd_reg(OFS_IRQ_EN, d);
        chk(d, 8'h00);
        chk({7'h00, irq_o}, 8'h00);
        $display("test mid reset done");
        conclude();
    end
endmodule : pmc_monitor_bench
